// >>> hdl/sdt_pkg.sv
// Shared constants and types for the strobe, input filter and timer unit
package sdt_pkg;
    // Clock and tick timing
    localparam int unsigned CLK_PERIOD_NS  = 10;          // 100 MHz system clock
    localparam int unsigned HALF_US_NS     = 500;         // Base filter tick, ns
    localparam int unsigned HALF_US_CYCLES = HALF_US_NS / CLK_PERIOD_NS;
    localparam logic [5:0]  HALF_TICK_LAST = 6'(HALF_US_CYCLES - 1);

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;  // Source and launch selection
    localparam logic [7:0] OFS_RESTART = 8'h04;  // Bit 0 write issues restart
    localparam logic [7:0] OFS_FILTER  = 8'h08;  // Filter time, half-us units
    localparam logic [7:0] OFS_LAG     = 8'h0c;  // Start lag, us
    localparam logic [7:0] OFS_PULSE   = 8'h10;  // Pulse length, us
    localparam logic [7:0] OFS_EXPO    = 8'h14;  // Exposure time, us
    localparam logic [7:0] OFS_RDOUT   = 8'h18;  // Readout time, us
    localparam logic [7:0] OFS_STATUS  = 8'h1c;  // Counter state and levels
    localparam logic [7:0] OFS_COUNT   = 8'h20;  // Running count, us

    // Control register field positions
    localparam int unsigned CTRL_LINE_LSB   = 0;
    localparam int unsigned CTRL_LAUNCH_LSB = 4;
    localparam int unsigned CTRL_COND_LSB   = 8;

    // Reset values
    localparam logic [20:0] FILTER_RESET = 21'h000001;  // One half microsecond
    localparam logic [25:0] LAG_RESET    = 26'h0000000;
    localparam logic [25:0] PULSE_RESET  = 26'h0000001;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Output line selections
    typedef enum logic [2:0] {
        LINE_OFF = 3'h0, LINE_EXPOSURE = 3'h1, LINE_READOUT = 3'h2,
        LINE_TIMER = 3'h3, LINE_STROBE = 3'h4
    } sdt_line_t;

    // Launch sources
    typedef enum logic [2:0] {
        SRC_OFF = 3'h0, SRC_EXPOSURE = 3'h1, SRC_READOUT = 3'h2,
        SRC_EXT_ZERO = 3'h3, SRC_STROBE = 3'h4
    } sdt_src_t;

    // Launch conditions
    typedef enum logic [1:0] {
        COND_UP = 2'h0, COND_DOWN = 2'h1, COND_HIGH = 2'h2, COND_LOW = 2'h3
    } sdt_cond_t;

    // Counter states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1, ST_WAIT = 4'h2, ST_LAG = 4'h4, ST_RUN = 4'h8
    } sdt_state_t;

    // Software settings, carried together
    typedef struct packed {
        logic [2:0]  line_output_source;
        logic [2:0]  launch_source;
        logic [1:0]  launch_condition;
        logic [20:0] filter_half_us;
        logic [25:0] start_lag_setting;
        logic [25:0] pulse_length_setting;
        logic [31:0] exposure_us;
        logic [31:0] readout_us;
    } sdt_cfg_t;
endpackage

// >>> hdl/sdt_io.sv
// Strobe generator, input filter and launchable pulse timer behind AXI4-Lite
// Operation
// - Strobe selection drives strobe onto output line
// - Strobe spans bottom-row start to top-row end
// - Strobe only when exposure exceeds readout
// - Input level accepted after holding filter time
// - Shorter input pulses dropped, level kept
// - Valid transition delayed by filter time
// - Filter time programmable, half microsecond default
// - Timer selection drives timer onto line
// - Pulse length 1 to 60e6 us, edges only
// - Start lag 0 to 60e6 us before active
// - Restart clears state and count, restarts
// - Running count readable at any time
// - Reports idle, waiting or running state
// - Launch source off, exposure, readout, input, strobe
// - Chosen rising or falling edge launches timer
// - Level modes follow source high or low
// - Level high waits lag then follows source
//
// Design decisions made here: the address map and the AXI4-Lite register port.
module sdt_io (
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    input  wire logic        TOP_ROW_EXPOSING_I,
    input  wire logic        BOTTOM_ROW_EXPOSING_I,
    input  wire logic        EXPOSURE_WINDOW_I,
    input  wire logic        READOUT_WINDOW_I,
    input  wire logic        EXTERNAL_INPUT_ZERO_I,
    output logic             LINE_OUT_O,
    input  wire logic [7:0]  S_AXI_AWADDR_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    output logic [1:0]       S_AXI_BRESP_O,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    input  wire logic [7:0]  S_AXI_ARADDR_I,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I
);
    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old_w,
                                          input logic [31:0] new_w,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Mapped offset check, shared by read and write decode
    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= sdt_pkg::OFS_COUNT);
    endfunction

    // Bus and settings state
    sdt_pkg::sdt_cfg_t cfg_reg, cfg_next;          // Software settings
    logic              awready_reg, awready_next;  // Write address ready
    logic              wready_reg, wready_next;    // Write data ready
    logic              aw_have_reg, aw_have_next;  // Address held
    logic              w_have_reg, w_have_next;    // Data held
    logic [7:0]        awaddr_reg, awaddr_next;    // Held write address
    logic [31:0]       wdata_reg, wdata_next;      // Held write data
    logic [3:0]        wstrb_reg, wstrb_next;      // Held byte enables
    logic              bvalid_reg, bvalid_next;    // Write response valid
    logic [1:0]        bresp_reg, bresp_next;      // Write response code
    logic              arready_reg, arready_next;  // Read address ready
    logic              rvalid_reg, rvalid_next;    // Read data valid
    logic [31:0]       rdata_reg, rdata_next;      // Read data
    logic [1:0]        rresp_reg, rresp_next;      // Read response code
    logic              restart_reg, restart_next;  // One-cycle restart pulse

    // Tick, filter, strobe and timer state
    logic [5:0]          half_cnt_reg, half_cnt_next;  // Half-us divider
    logic                us_phase_reg, us_phase_next;  // Second half of a us
    logic                filt_reg, filt_next;          // Accepted input level
    logic [20:0]         fcnt_reg, fcnt_next;          // Filter hold counter
    logic                strobe_reg, strobe_next;      // Strobe pulse
    logic                src_prev_reg, src_prev_next;  // Source, last cycle
    sdt_pkg::sdt_state_t state_reg, state_next;        // Counter state
    logic [25:0]         count_reg, count_next;        // Running count
    logic                line_reg, line_next;          // Output line

    logic        half_tick;     // Half-microsecond enable
    logic        us_tick;       // Microsecond enable
    logic        src;           // Selected launch source
    logic        lvl;           // Source at its configured active level
    logic        edge_hit;      // Configured edge seen this cycle
    logic        level_mode;    // Level-follow conditions
    logic [25:0] pulse_eff;     // Pulse length, never below one
    logic [1:0]  state_code;    // Encoded counter state for software
    logic        wr_fire;       // Write commits this cycle
    logic [31:0] ctrl_word;     // Control fields as software sees them

    // Dividers: one-cycle enables from the single clock
    assign half_tick = (half_cnt_reg == sdt_pkg::HALF_TICK_LAST);
    assign us_tick   = half_tick & us_phase_reg;

    // Register bus: next values for both channels and the settings
    always_comb begin
        cfg_next     = cfg_reg;
        aw_have_next = aw_have_reg;
        w_have_next  = w_have_reg;
        awaddr_next  = awaddr_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        arready_next = arready_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        restart_next = 1'b0;
        // Address and data are taken independently, in either order
        if (S_AXI_AWVALID_I && awready_reg) begin
            aw_have_next = 1'b1;
            awaddr_next  = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && wready_reg) begin
            w_have_next = 1'b1;
            wdata_next  = S_AXI_WDATA_I;
            wstrb_next  = S_AXI_WSTRB_I;
        end
        // Response retires before the next write may commit
        if (bvalid_reg && S_AXI_BREADY_I) begin
            bvalid_next = 1'b0;
        end
        wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
        if (wr_fire) begin
            aw_have_next = 1'b0;
            w_have_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = mapped(awaddr_reg) ? sdt_pkg::RESP_OKAY : sdt_pkg::RESP_SLVERR;
            case (awaddr_reg)
                sdt_pkg::OFS_CTRL: begin
                    {cfg_next.launch_condition, cfg_next.launch_source,
                     cfg_next.line_output_source} =
                        {2'(merge(ctrl_word, wdata_reg, wstrb_reg) >> 8),
                         3'(merge(ctrl_word, wdata_reg, wstrb_reg) >> 4),
                         3'(merge(ctrl_word, wdata_reg, wstrb_reg))};
                end
                sdt_pkg::OFS_RESTART: begin
                    restart_next = wstrb_reg[0] & wdata_reg[0];
                end
                sdt_pkg::OFS_FILTER: begin
                    cfg_next.filter_half_us =
                        21'(merge({11'h0, cfg_reg.filter_half_us}, wdata_reg, wstrb_reg));
                end
                sdt_pkg::OFS_LAG: begin
                    cfg_next.start_lag_setting =
                        26'(merge({6'h0, cfg_reg.start_lag_setting}, wdata_reg, wstrb_reg));
                end
                sdt_pkg::OFS_PULSE: begin
                    cfg_next.pulse_length_setting =
                        26'(merge({6'h0, cfg_reg.pulse_length_setting}, wdata_reg, wstrb_reg));
                end
                sdt_pkg::OFS_EXPO: begin
                    cfg_next.exposure_us = merge(cfg_reg.exposure_us, wdata_reg, wstrb_reg);
                end
                sdt_pkg::OFS_RDOUT: begin
                    cfg_next.readout_us = merge(cfg_reg.readout_us, wdata_reg, wstrb_reg);
                end
                default: begin
                    // Status, count and unmapped offsets ignore writes
                end
            endcase
        end
        // Hold off new address and data while one is pending or answered
        awready_next = !aw_have_next && !bvalid_next;
        wready_next  = !w_have_next && !bvalid_next;
        // Read channel: one read at a time
        if (rvalid_reg && S_AXI_RREADY_I) begin
            rvalid_next  = 1'b0;
            arready_next = 1'b1;
        end
        if (S_AXI_ARVALID_I && arready_reg) begin
            arready_next = 1'b0;
            rvalid_next  = 1'b1;
            rresp_next   = mapped(S_AXI_ARADDR_I) ? sdt_pkg::RESP_OKAY : sdt_pkg::RESP_SLVERR;
            case (S_AXI_ARADDR_I)
                sdt_pkg::OFS_CTRL:   rdata_next = ctrl_word;
                sdt_pkg::OFS_FILTER: rdata_next = {11'h0, cfg_reg.filter_half_us};
                sdt_pkg::OFS_LAG:    rdata_next = {6'h0, cfg_reg.start_lag_setting};
                sdt_pkg::OFS_PULSE:  rdata_next = {6'h0, cfg_reg.pulse_length_setting};
                sdt_pkg::OFS_EXPO:   rdata_next = cfg_reg.exposure_us;
                sdt_pkg::OFS_RDOUT:  rdata_next = cfg_reg.readout_us;
                sdt_pkg::OFS_STATUS: rdata_next = {26'h0, strobe_reg, filt_reg,
                                                   2'h0, state_code};
                sdt_pkg::OFS_COUNT:  rdata_next = {6'h0, count_reg};
                default:             rdata_next = 32'h0;
            endcase
        end
    end

    // Register bus: registers only
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cfg_reg                      <= '0;
            cfg_reg.filter_half_us       <= sdt_pkg::FILTER_RESET;
            cfg_reg.start_lag_setting    <= sdt_pkg::LAG_RESET;
            cfg_reg.pulse_length_setting <= sdt_pkg::PULSE_RESET;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 32'h0;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= sdt_pkg::RESP_OKAY;
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0;
            rresp_reg   <= sdt_pkg::RESP_OKAY;
            restart_reg <= 1'b0;
        end else begin
            cfg_reg     <= cfg_next;
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            aw_have_reg <= aw_have_next;
            w_have_reg  <= w_have_next;
            awaddr_reg  <= awaddr_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            restart_reg <= restart_next;
        end
    end

    // Launch source, level and edge decode
    always_comb begin
        // Control fields as software reads them
        ctrl_word = {22'h0, cfg_reg.launch_condition, 1'b0, cfg_reg.launch_source, 1'b0,
                     cfg_reg.line_output_source};
        case (sdt_pkg::sdt_src_t'(cfg_reg.launch_source))
            sdt_pkg::SRC_EXPOSURE: src = EXPOSURE_WINDOW_I;
            sdt_pkg::SRC_READOUT:  src = READOUT_WINDOW_I;
            sdt_pkg::SRC_EXT_ZERO: src = filt_reg;
            sdt_pkg::SRC_STROBE:   src = strobe_reg;
            default:               src = 1'b0;
        endcase
        level_mode = cfg_reg.launch_condition[1];
        lvl = (cfg_reg.launch_condition == sdt_pkg::COND_LOW) ? !src : src;
        edge_hit = (cfg_reg.launch_condition == sdt_pkg::COND_UP) ?
                   (src && !src_prev_reg) : (!src && src_prev_reg);
        // A zero pulse length would vanish; it acts as one microsecond
        pulse_eff = (cfg_reg.pulse_length_setting == 26'h0) ? 26'h1 :
                    cfg_reg.pulse_length_setting;
        // Lag counts as waiting: no output is driven yet
        case (state_reg)
            sdt_pkg::ST_RUN:  state_code = 2'h2;
            sdt_pkg::ST_IDLE: state_code = 2'h0;
            default:          state_code = 2'h1;
        endcase
    end

    // Tick, filter, strobe, counter and output line: next values
    always_comb begin
        half_cnt_next = half_tick ? 6'h0 : half_cnt_reg + 6'h1;
        us_phase_next = half_tick ? !us_phase_reg : us_phase_reg;
        // Input filter: accept only after the level has held long enough
        filt_next = filt_reg;
        fcnt_next = fcnt_reg;
        if (EXTERNAL_INPUT_ZERO_I == filt_reg) begin
            fcnt_next = 21'h0;
        end else if (fcnt_reg >= cfg_reg.filter_half_us) begin
            filt_next = EXTERNAL_INPUT_ZERO_I;
            fcnt_next = 21'h0;
        end else if (half_tick) begin
            fcnt_next = fcnt_reg + 21'h1;
        end
        // Overlap of the top and bottom rows' exposure windows
        strobe_next = TOP_ROW_EXPOSING_I && BOTTOM_ROW_EXPOSING_I
                      && (cfg_reg.exposure_us > cfg_reg.readout_us);
        src_prev_next = src;
        state_next    = state_reg;
        count_next    = count_reg;
        case (state_reg)
            sdt_pkg::ST_IDLE: begin
                state_next = sdt_pkg::ST_WAIT;
                count_next = 26'h0;
            end
            sdt_pkg::ST_WAIT: begin
                count_next = 26'h0;
                if (level_mode ? lvl : edge_hit) begin
                    state_next = sdt_pkg::ST_LAG;
                end
            end
            sdt_pkg::ST_LAG: begin
                if (level_mode && !lvl) begin
                    state_next = sdt_pkg::ST_WAIT;
                end else if (count_reg >= cfg_reg.start_lag_setting) begin
                    state_next = sdt_pkg::ST_RUN;
                    count_next = 26'h0;
                end else if (us_tick) begin
                    count_next = count_reg + 26'h1;
                end
            end
            sdt_pkg::ST_RUN: begin
                if (level_mode) begin
                    if (!lvl) begin
                        state_next = sdt_pkg::ST_WAIT;
                    end else if (us_tick) begin
                        count_next = count_reg + 26'h1;
                    end
                end else if (count_reg >= pulse_eff) begin
                    state_next = sdt_pkg::ST_WAIT;
                end else if (us_tick) begin
                    count_next = count_reg + 26'h1;
                end
            end
            default: begin
                state_next = sdt_pkg::ST_IDLE;
            end
        endcase
        // Source off parks the counter; restart clears it and returns it to waiting for a launch
        if (cfg_reg.launch_source == sdt_pkg::SRC_OFF) begin
            state_next = sdt_pkg::ST_IDLE;
            count_next = 26'h0;
        end else if (restart_reg) begin
            state_next = sdt_pkg::ST_WAIT;
            count_next = 26'h0;
        end
        case (sdt_pkg::sdt_line_t'(cfg_reg.line_output_source))
            sdt_pkg::LINE_EXPOSURE: line_next = EXPOSURE_WINDOW_I;
            sdt_pkg::LINE_READOUT:  line_next = READOUT_WINDOW_I;
            sdt_pkg::LINE_TIMER:    line_next = (state_reg == sdt_pkg::ST_RUN);
            sdt_pkg::LINE_STROBE:   line_next = strobe_reg;
            default:                line_next = 1'b0;
        endcase
    end

    // Tick, filter, strobe, counter and output line: registers only
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            half_cnt_reg <= 6'h0;
            us_phase_reg <= 1'b0;
            filt_reg     <= 1'b0;
            fcnt_reg     <= 21'h0;
            strobe_reg   <= 1'b0;
            src_prev_reg <= 1'b0;
            state_reg    <= sdt_pkg::ST_IDLE;
            count_reg    <= 26'h0;
            line_reg     <= 1'b0;
        end else begin
            half_cnt_reg <= half_cnt_next;
            us_phase_reg <= us_phase_next;
            filt_reg     <= filt_next;
            fcnt_reg     <= fcnt_next;
            strobe_reg   <= strobe_next;
            src_prev_reg <= src_prev_next;
            state_reg    <= state_next;
            count_reg    <= count_next;
            line_reg     <= line_next;
        end
    end

    // Outputs straight from flip-flops
    assign LINE_OUT_O      = line_reg;
    assign S_AXI_AWREADY_O = awready_reg;
    assign S_AXI_WREADY_O  = wready_reg;
    assign S_AXI_BVALID_O  = bvalid_reg;
    assign S_AXI_BRESP_O   = bresp_reg;
    assign S_AXI_ARREADY_O = arready_reg;
    assign S_AXI_RVALID_O  = rvalid_reg;
    assign S_AXI_RDATA_O   = rdata_reg;
    assign S_AXI_RRESP_O   = rresp_reg;
endmodule

// >>> dv/sdt_io_sva.sv
// Bus handshake checker for the strobe, filter and timer unit
module sdt_io_sva (
    input wire logic        CLK_I, RST_I, S_AXI_AWVALID_I, S_AXI_AWREADY_O,
    input wire logic        S_AXI_WVALID_I, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_BREADY_I,
    input wire logic        S_AXI_ARVALID_I, S_AXI_ARREADY_O, S_AXI_RVALID_O, S_AXI_RREADY_I,
    input wire logic [1:0]  S_AXI_RRESP_O,
    input wire logic [31:0] S_AXI_RDATA_O
);
    timeunit 1ns;
    timeprecision 1ps;
    // One clock domain, so one clocking and one disable
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    wire aw_t = S_AXI_AWVALID_I && S_AXI_AWREADY_O;  // Write address taken
    wire ar_t = S_AXI_ARVALID_I && S_AXI_ARREADY_O;  // Read address taken
    // Commit edge first, answer one edge later
    sequence s_wr; aw_t && S_AXI_WVALID_I && S_AXI_WREADY_O; endsequence
    sequence s_resp; !S_AXI_BVALID_O ##1 S_AXI_BVALID_O; endsequence
    property p_aw_busy; aw_t |=> !S_AXI_AWREADY_O; endproperty
    a_aw_busy: assert property (p_aw_busy) else $error("address open");
    property p_w_busy; S_AXI_WVALID_I && S_AXI_WREADY_O |=> !S_AXI_WREADY_O; endproperty
    a_w_busy: assert property (p_w_busy) else $error("data open");
    property p_b_lat; s_wr |=> s_resp; endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer timing");
    property p_b_lock; S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O; endproperty
    a_b_lock: assert property (p_b_lock) else $error("write taken early");
    property p_b_end; S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O && S_AXI_AWREADY_O;
    endproperty
    a_b_end: assert property (p_b_end) else $error("write not closed");
    property p_r_lat; ar_t |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O; endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer timing");
    property p_r_err; S_AXI_RVALID_O && S_AXI_RRESP_O == 2'h2 |-> S_AXI_RDATA_O == 32'h0;
    endproperty
    a_r_err: assert property (p_r_err) else $error("error read data");
    property p_r_end; S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O && S_AXI_ARREADY_O;
    endproperty
    a_r_end: assert property (p_r_end) else $error("read not closed");
endmodule
bind sdt_io sdt_io_sva u_sva (.*);

// >>> dv/sdt_partner.sv
// Trigger source and flash model at the far side of the line
module sdt_partner (
    input  wire logic clk_i,
    input  wire logic line_i,
    output logic      ext_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int   flashes = 0;     // Flash firings seen
    logic line_q  = 1'b0;  // Line one edge ago
    initial ext_o = 1'b0;
    // Trigger level set just after an edge, then held
    task automatic drive(input logic lvl, input int cyc);
        ext_o <= lvl;
        repeat (cyc) @(posedge clk_i);
    endtask
    // Flash fires on each rising line
    always @(posedge clk_i) begin
        line_q <= line_i;
        if (line_i && !line_q) flashes++;
    end
endmodule

// >>> dv/sdt_io_bench.sv
// Self-checking bench for the strobe, filter and timer unit
module sdt_io_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK_I = 1'b0, RST_I = 1'b1, TOP_ROW_EXPOSING_I = 1'b0, BOTTOM_ROW_EXPOSING_I = 1'b0;
    logic EXPOSURE_WINDOW_I = 1'b0, READOUT_WINDOW_I = 1'b0, EXTERNAL_INPUT_ZERO_I, LINE_OUT_O;
    logic [7:0] S_AXI_AWADDR_I = 8'h0, S_AXI_ARADDR_I = 8'h0;
    logic [31:0] S_AXI_WDATA_I = 32'h0, S_AXI_RDATA_O;
    logic [3:0] S_AXI_WSTRB_I = 4'hf;
    logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
    logic S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0, S_AXI_BREADY_I = 1'b0;
    logic S_AXI_ARVALID_I = 1'b0, S_AXI_RREADY_I = 1'b0;
    logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
    logic [33:0] q;  // Last answer: response, then data
    int err_total = 0, n_tests = 0, n;
    // Reset rows: address, then response and data; last two are refused
    logic [7:0] ra [10] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h02};
    logic [33:0] re [10] = '{0, 1, 0, 1, 0, 0, 0, 0, 34'h200000000, 34'h200000000};
    // Control rows for level modes and sources, with line expected
    logic [31:0] cw [8] = '{32'h213, 32'h313, 32'h223, 32'h233, 32'h243, 32'h203,
                            32'h001, 32'h002};
    logic le [8] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    sdt_io DUT (.*);
    sdt_partner PT (.clk_i(CLK_I), .line_i(LINE_OUT_O), .ext_o(EXTERNAL_INPUT_ZERO_I));
    initial forever #5 CLK_I = ~CLK_I;
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        n_tests++;
        if (s !== e) begin
            err_total++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Bus waits are bounded; running out ends the run
    task automatic guard();
        if (n >= 60) begin
            err_total++;
            report_and_stop();
        end
    endtask
    task automatic ln(input int c, input logic e);
        repeat (c) @(posedge CLK_I);
        chk(34'(LINE_OUT_O), 34'(e));
    endtask
    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        n = 0;
        @(posedge CLK_I);
        S_AXI_AWADDR_I <= a;
        S_AXI_WDATA_I <= v;
        S_AXI_AWVALID_I <= 1'b1;
        S_AXI_WVALID_I <= 1'b1;
        S_AXI_BREADY_I <= 1'b1;
        do begin
            @(posedge CLK_I);
            if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'b0;
            if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'b0;
            n++;
        end while (!S_AXI_BVALID_O && n < 60);
        q = 34'(S_AXI_BRESP_O);
        S_AXI_BREADY_I <= 1'b0;
        guard();
    endtask
    task automatic rd(input logic [7:0] a);
        n = 0;
        @(posedge CLK_I);
        S_AXI_ARADDR_I <= a;
        S_AXI_ARVALID_I <= 1'b1;
        S_AXI_RREADY_I <= 1'b1;
        do begin
            @(posedge CLK_I);
            if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'b0;
            n++;
        end while (!S_AXI_RVALID_O && n < 60);
        q = {S_AXI_RRESP_O, S_AXI_RDATA_O};
        S_AXI_RREADY_I <= 1'b0;
        guard();
    endtask
    initial begin
        repeat (3) @(posedge CLK_I);
        ln(0, 1'b0);
        RST_I <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd(ra[i]);
            chk(q, re[i]);
        end
        wr(8'h24, 32'h1);
        chk(q, 34'h2);
        wr(8'h20, 32'h1);
        chk(q, 34'h0);
        wr(8'h14, 32'h0a);
        wr(8'h18, 32'h05);
        wr(8'h00, 32'h04);
        TOP_ROW_EXPOSING_I <= 1'b1;
        ln(4, 1'b0);
        BOTTOM_ROW_EXPOSING_I <= 1'b1;
        ln(4, 1'b1);
        TOP_ROW_EXPOSING_I <= 1'b0;
        ln(4, 1'b0);
        wr(8'h18, 32'h0a);
        TOP_ROW_EXPOSING_I <= 1'b1;
        ln(4, 1'b0);
        TOP_ROW_EXPOSING_I <= 1'b0;
        BOTTOM_ROW_EXPOSING_I <= 1'b0;
        // Two microsecond filter: short pulse dropped, long level taken late
        wr(8'h08, 32'h04);
        PT.drive(1'b1, 100);
        PT.drive(1'b0, 300);
        rd(8'h1c);
        chk(34'(q[4]), 34'h0);
        PT.drive(1'b1, 140);
        rd(8'h1c);
        chk(34'(q[4]), 34'h0);
        repeat (70) @(posedge CLK_I);
        rd(8'h1c);
        chk(34'(q[4]), 34'h1);
        // Rising edge launch with lag 1 us and pulse 5 us
        wr(8'h0c, 32'h01);
        wr(8'h10, 32'h05);
        wr(8'h00, 32'h13);
        rd(8'h1c);
        chk(34'(q[1:0]), 34'h1);
        EXPOSURE_WINDOW_I <= 1'b1;
        ln(3, 1'b0);
        ln(180, 1'b1);
        rd(8'h1c);
        chk(34'(q[1:0]), 34'h2);
        ln(1000, 1'b0);
        rd(8'h1c);
        chk(34'(q[1:0]), 34'h1);
        chk(34'(PT.flashes), 34'h2);
        EXPOSURE_WINDOW_I <= 1'b0;
        repeat (2) @(posedge CLK_I);
        EXPOSURE_WINDOW_I <= 1'b1;
        ln(250, 1'b1);
        wr(8'h04, 32'h01);
        rd(8'h20);
        chk(q, 34'h0);
        ln(0, 1'b0);
        wr(8'h0c, 32'h00);
        wr(8'h00, 32'h113);
        EXPOSURE_WINDOW_I <= 1'b0;
        ln(10, 1'b1);
        READOUT_WINDOW_I <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr(8'h00, cw[i]);
            ln(10, le[i]);
        end
        rd(8'h1c);
        chk(34'(q[1:0]), 34'h0);
        wr(8'h00, 32'h213);
        EXPOSURE_WINDOW_I <= 1'b1;
        ln(10, 1'b1);
        EXPOSURE_WINDOW_I <= 1'b0;
        ln(5, 1'b0);
        report_and_stop();
    end
endmodule
